// file: rtl/swi_pkg.sv
// Purpose: Shared constants and types for the single-wire token link.
// Assumes: Core clock of 10 MHz (100 ns period).
// Notes:   Times are kept in their own units; cycle counts derive from them.
package swi_pkg;

  // ----------------------------------------------------------------------
  // Clock and token timing
  // ----------------------------------------------------------------------
  localparam int CLK_NS          = 100;
  localparam int WAKE_LOW_NS     = 60000;
  localparam int SLEEP_GLITCH_NS = 500;
  localparam int ACT_GLITCH_NS   = 45;
  localparam int PULSE_NS        = 6000;
  localparam int BIT_NS          = 54000;
  localparam int TURN_NS         = 60000;
  localparam int DECIDE_NS       = 25000;
  localparam int IO_IDLE_MS      = 65;
  localparam int IGNORE_MS       = 25;
  localparam int WATCHDOG_S      = 4;

  localparam int WAKE_LOW_CYC     = (WAKE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLEEP_GLITCH_CYC = (SLEEP_GLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACT_GLITCH_CYC   = (ACT_GLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC        = PULSE_NS / CLK_NS;
  localparam int BIT_CYC          = BIT_NS / CLK_NS;
  localparam int TURN_CYC         = TURN_NS / CLK_NS;
  localparam int DECIDE_CYC       = DECIDE_NS / CLK_NS;
  localparam int IO_IDLE_CYC      = IO_IDLE_MS * 1000000 / CLK_NS;
  localparam int IGNORE_CYC       = IGNORE_MS * 1000000 / CLK_NS;
  localparam longint WATCHDOG_CYC =
    longint'(WATCHDOG_S) * 1000000000 / CLK_NS;

  localparam int CNT_W = 32;

  // ----------------------------------------------------------------------
  // Flags and identity
  // ----------------------------------------------------------------------
  localparam logic [7:0] FLAG_CMD   = 8'h66;
  localparam logic [7:0] FLAG_TX    = 8'h99;
  localparam logic [7:0] FLAG_SLEEP = 8'hcc;
  localparam int         BITS_PER_FLAG = 8;

  // Arbitrary value for the mask-stored part of the maker code.
  localparam logic [15:0] MASK_MAKER_ID = 16'h5a5a;

  typedef enum logic [2:0] {
    ST_SLEEP = 3'b000,
    ST_RX    = 3'b001,
    ST_BUSY  = 3'b010,
    ST_TURN  = 3'b011,
    ST_TX    = 3'b100,
    ST_PAUSE = 3'b101
  } link_state_t;

endpackage

// file: rtl/swi_bit_if.sv
// Purpose: Carries one outgoing bit from the link controller to the driver.
// Assumes: Both ends on mclk_i.
// Notes:   go is a one-cycle pulse; done pulses when the bit period ends.
`timescale 1ns/10ps
`default_nettype none
interface swi_bit_if;
  logic go;
  logic bit_val;
  logic done;
  modport ctrl (output go, output bit_val, input done);
  modport drv  (input go, input bit_val, output done);
endinterface
`default_nettype wire

// file: rtl/swi_bit_driver.sv
// Purpose: Shapes one device-side bit token on the wire.
// Assumes: go only arrives while idle.
// Notes:   A one is a lone start pulse; a zero adds a high and a low pulse.
`timescale 1ns/10ps
`default_nettype none
module swi_bit_driver (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  // Bit request
  swi_bit_if.drv    bit_if,
  // Wire drive
  output logic      line_low_o
);
  import swi_pkg::*;

  logic             act_r,  act_nxt;
  logic             val_r,  val_nxt;
  logic [CNT_W-1:0] t_r,    t_nxt;
  logic             low_r,  low_nxt;
  logic             done_r, done_nxt;

  // ----------------------------------------------------------------------
  // Token timing
  // ----------------------------------------------------------------------
  always_comb begin
    act_nxt  = act_r;
    val_nxt  = val_r;
    t_nxt    = t_r;
    low_nxt  = 1'b0;
    done_nxt = 1'b0;
    if (!act_r) begin
      if (bit_if.go) begin
        act_nxt = 1'b1;
        val_nxt = bit_if.bit_val;
        t_nxt   = '0;
        low_nxt = 1'b1;
      end
    end else begin
      t_nxt = t_r + 1'b1;
      if (t_nxt < CNT_W'(PULSE_CYC)) begin
        low_nxt = 1'b1;
      end else if (!val_r && t_nxt >= CNT_W'(2 * PULSE_CYC)
                   && t_nxt < CNT_W'(3 * PULSE_CYC)) begin
        low_nxt = 1'b1;
      end
      if (t_r == CNT_W'(BIT_CYC - 1)) begin
        act_nxt  = 1'b0;
        done_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      act_r  <= 1'b0;
      val_r  <= 1'b0;
      t_r    <= '0;
      low_r  <= 1'b0;
      done_r <= 1'b0;
    end else begin
      act_r  <= act_nxt;
      val_r  <= val_nxt;
      t_r    <= t_nxt;
      low_r  <= low_nxt;
      done_r <= done_nxt;
    end
  end

  assign line_low_o  = low_r;
  assign bit_if.done = done_r;

endmodule
`default_nettype wire

// file: rtl/swi_link.sv
// Purpose: Device end of the single-wire pulse-count token link.
// Assumes: The digest engine and command parser sit outside this block.
// Notes:   Bits travel least significant first; the wire is open drain.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - One shared wire, asynchronous timing, data carried by pulse counts.
// - Eight bit tokens form a flag that sets meaning of following bits.
// - Blocks carry a byte count and checksum around the packet.
// - Digest the challenge; reply only whether it matches the response.
// - Every digest includes the 24-bit maker code, mask and fuse parts.
// - Secret fuse bits join the digest only when the command asks.
// - A low of at least 60 us wakes the sleeping device.
// - Wake-to-data delay past the IO idle limit returns to sleep.
// - Same waveforms both ways; device pulses 4.6 to 8.6 us wide.
// - System bits at least 37 us apart; idle beyond limit means sleep.
// - First device falling edge 28 to 95 us after a transmit flag.
// - While active, ignore pulses narrower than 45 ns.
// - While asleep, ignore low pulses narrower than 500 ns.
// - Watchdog forces sleep 3 to 5.7 s after each wake.
// - After a bus-ignore command, ignore the wire for about 25 ms.
// - Flags 0x66 command, 0x99 transmit, 0xcc sleep; others ignored.
// - Stay busy and ignore the wire while a command executes.
module swi_link #(
  parameter int     IO_IDLE_LIMIT = swi_pkg::IO_IDLE_CYC,
  parameter int     IGNORE_LIMIT  = swi_pkg::IGNORE_CYC,
  parameter longint WDOG_LIMIT    = swi_pkg::WATCHDOG_CYC
) (
  // Clock and reset
  input  wire logic         mclk_i,
  input  wire logic         sys_rst_i,
  // Single wire, open drain
  input  wire logic         sig_i,
  output logic              sig_o,
  output logic              sig_oe_o,
  // Received command block bytes
  output logic [7:0]        rx_data_o,
  output logic              rx_valid_o,
  output logic              cmd_end_o,
  input  wire logic         busy_i,
  input  wire logic         bus_ignore_command_i,
  // Reply bytes
  input  wire logic [7:0]   tx_data_i,
  input  wire logic         tx_valid_i,
  input  wire logic         tx_last_i,
  output logic              tx_ready_o,
  // Digest support
  input  wire logic [7:0]   fuse_maker_i,
  input  wire logic [63:0]  secret_fuses_i,
  input  wire logic         secret_req_i,
  input  wire logic [255:0] digest_i,
  input  wire logic [255:0] response_i,
  input  wire logic         compare_i,
  output logic [23:0]       maker_ident_code_o,
  output logic [63:0]       secret_word_o,
  output logic              verdict_o,
  // Power state
  output logic              asleep_o
);
  import swi_pkg::*;

  swi_bit_if bit_if ();
  logic line_low;

  swi_bit_driver u_drv (
    .mclk_i     (mclk_i),
    .sys_rst_i  (sys_rst_i),
    .bit_if     (bit_if),
    .line_low_o (line_low)
  );

  // ----------------------------------------------------------------------
  // Wire input synchroniser and glitch filter
  // ----------------------------------------------------------------------
  logic s1_r, s2_r, s3_r, filt_r, prev_r;
  logic s1_nxt, s2_nxt, s3_nxt, filt_nxt, prev_nxt;
  logic fall;

  always_comb begin
    s1_nxt   = sig_i;
    s2_nxt   = s1_r;
    s3_nxt   = s2_r;
    filt_nxt = filt_r;
    if (s2_r == s3_r) begin
      filt_nxt = s2_r;
    end
    prev_nxt = filt_r;
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1_r   <= 1'b1;
      s2_r   <= 1'b1;
      s3_r   <= 1'b1;
      filt_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      s1_r   <= s1_nxt;
      s2_r   <= s2_nxt;
      s3_r   <= s3_nxt;
      filt_r <= filt_nxt;
      prev_r <= prev_nxt;
    end
  end

  assign fall = prev_r & ~filt_r;

  // ----------------------------------------------------------------------
  // Link state machine
  // ----------------------------------------------------------------------
  link_state_t      state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [63:0]      wd_r, wd_nxt;
  logic [CNT_W-1:0] bt_r, bt_nxt;
  logic             inbit_r, inbit_nxt;
  logic             seen2_r, seen2_nxt;
  logic [7:0]       sh_r, sh_nxt;
  logic [3:0]       bitn_r, bitn_nxt;
  logic             cmd_r, cmd_nxt;
  logic             first_r, first_nxt;
  logic [7:0]       left_r, left_nxt;
  logic [7:0]       rxd_r, rxd_nxt;
  logic             rxv_r, rxv_nxt;
  logic             cend_r, cend_nxt;
  logic [7:0]       txb_r, txb_nxt;
  logic             txlast_r, txlast_nxt;
  logic             txact_r, txact_nxt;
  logic [3:0]       txn_r, txn_nxt;
  logic             go_r, go_nxt;
  logic [7:0]       byte_in;

  assign byte_in = {~seen2_r, sh_r[7:1]};

  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    wd_nxt     = wd_r;
    bt_nxt     = bt_r;
    inbit_nxt  = inbit_r;
    seen2_nxt  = seen2_r;
    sh_nxt     = sh_r;
    bitn_nxt   = bitn_r;
    cmd_nxt    = cmd_r;
    first_nxt  = first_r;
    left_nxt   = left_r;
    rxd_nxt    = rxd_r;
    rxv_nxt    = 1'b0;
    cend_nxt   = 1'b0;
    txb_nxt    = txb_r;
    txlast_nxt = txlast_r;
    txact_nxt  = txact_r;
    txn_nxt    = txn_r;
    go_nxt     = 1'b0;
    if (state_r != ST_SLEEP) begin
      wd_nxt = wd_r + 64'h1;
    end
    case (state_r)
      ST_SLEEP: begin
        if (!filt_r) begin
          cnt_nxt = cnt_r + 1'b1;
        end else begin
          cnt_nxt = '0;
        end
        if (!filt_r && cnt_r >= CNT_W'(SLEEP_GLITCH_CYC)
            && cnt_r == CNT_W'(WAKE_LOW_CYC - 1)) begin
          state_nxt = ST_RX;
          cnt_nxt   = '0;
          wd_nxt    = '0;
          inbit_nxt = 1'b0;
          bitn_nxt  = '0;
          cmd_nxt   = 1'b0;
        end
      end
      ST_RX: begin
        cnt_nxt = fall ? '0 : cnt_r + 1'b1;
        if (cnt_r == CNT_W'(IO_IDLE_LIMIT - 1) && !inbit_r) begin
          state_nxt = ST_SLEEP;
          cnt_nxt   = '0;
        end
        if (!inbit_r) begin
          if (fall) begin
            inbit_nxt = 1'b1;
            bt_nxt    = '0;
            seen2_nxt = 1'b0;
          end
        end else begin
          bt_nxt = bt_r + 1'b1;
          if (fall) begin
            seen2_nxt = 1'b1;
          end
          if (bt_r == CNT_W'(DECIDE_CYC)) begin
            inbit_nxt = 1'b0;
            sh_nxt    = byte_in;
            bitn_nxt  = bitn_r + 1'b1;
            if (bitn_r == 4'(BITS_PER_FLAG - 1)) begin
              bitn_nxt = '0;
              if (cmd_r) begin
                rxd_nxt   = byte_in;
                rxv_nxt   = 1'b1;
                first_nxt = 1'b0;
                left_nxt  = first_r ? byte_in - 8'h1 : left_r - 8'h1;
                if ((first_r && byte_in <= 8'h1)
                    || (!first_r && left_r == 8'h1)) begin
                  cend_nxt  = 1'b1;
                  cmd_nxt   = 1'b0;
                  state_nxt = ST_BUSY;
                end
              end else begin
                case (byte_in)
                  FLAG_CMD: begin
                    cmd_nxt   = 1'b1;
                    first_nxt = 1'b1;
                  end
                  FLAG_TX: begin
                    state_nxt = ST_TURN;
                    cnt_nxt   = '0;
                  end
                  FLAG_SLEEP: begin
                    state_nxt = ST_SLEEP;
                    cnt_nxt   = '0;
                  end
                  default: begin
                    cmd_nxt = 1'b0;
                  end
                endcase
              end
            end
          end
        end
      end
      ST_BUSY: begin
        if (!busy_i && !cend_r) begin
          state_nxt = ST_RX;
          cnt_nxt   = '0;
          inbit_nxt = 1'b0;
        end
      end
      ST_TURN: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CNT_W'(TURN_CYC - 1)) begin
          state_nxt = ST_TX;
          txact_nxt = 1'b0;
        end
      end
      ST_TX: begin
        if (!txact_r) begin
          if (tx_valid_i) begin
            txb_nxt    = tx_data_i;
            txlast_nxt = tx_last_i;
            txact_nxt  = 1'b1;
            txn_nxt    = '0;
            go_nxt     = 1'b1;
          end
        end else if (bit_if.done) begin
          txb_nxt = {1'b0, txb_r[7:1]};
          txn_nxt = txn_r + 1'b1;
          if (txn_r == 4'(BITS_PER_FLAG - 1)) begin
            txact_nxt = 1'b0;
            if (txlast_r) begin
              state_nxt = ST_RX;
              cnt_nxt   = '0;
              inbit_nxt = 1'b0;
              bitn_nxt  = '0;
            end
          end else begin
            go_nxt = 1'b1;
          end
        end
      end
      ST_PAUSE: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CNT_W'(IGNORE_LIMIT - 1)) begin
          state_nxt = ST_RX;
          cnt_nxt   = '0;
          inbit_nxt = 1'b0;
          bitn_nxt  = '0;
        end
      end
      default: begin
        state_nxt = ST_SLEEP;
      end
    endcase
    if (bus_ignore_command_i && state_r != ST_SLEEP) begin
      state_nxt = ST_PAUSE;
      cnt_nxt   = '0;
    end
    if (state_r != ST_SLEEP && wd_r == 64'(WDOG_LIMIT - 1)) begin
      state_nxt = ST_SLEEP;
      cnt_nxt   = '0;
      go_nxt    = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r  <= ST_SLEEP;
      cnt_r    <= '0;
      wd_r     <= '0;
      bt_r     <= '0;
      inbit_r  <= 1'b0;
      seen2_r  <= 1'b0;
      sh_r     <= '0;
      bitn_r   <= '0;
      cmd_r    <= 1'b0;
      first_r  <= 1'b0;
      left_r   <= '0;
      rxd_r    <= '0;
      rxv_r    <= 1'b0;
      cend_r   <= 1'b0;
      txb_r    <= '0;
      txlast_r <= 1'b0;
      txact_r  <= 1'b0;
      txn_r    <= '0;
      go_r     <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      wd_r     <= wd_nxt;
      bt_r     <= bt_nxt;
      inbit_r  <= inbit_nxt;
      seen2_r  <= seen2_nxt;
      sh_r     <= sh_nxt;
      bitn_r   <= bitn_nxt;
      cmd_r    <= cmd_nxt;
      first_r  <= first_nxt;
      left_r   <= left_nxt;
      rxd_r    <= rxd_nxt;
      rxv_r    <= rxv_nxt;
      cend_r   <= cend_nxt;
      txb_r    <= txb_nxt;
      txlast_r <= txlast_nxt;
      txact_r  <= txact_nxt;
      txn_r    <= txn_nxt;
      go_r     <= go_nxt;
    end
  end

  assign bit_if.go      = go_r;
  assign bit_if.bit_val = txb_r[0];

  // ----------------------------------------------------------------------
  // Digest support registers
  // ----------------------------------------------------------------------
  logic [23:0] maker_r, maker_nxt;
  logic [63:0] secret_r, secret_nxt;
  logic        verdict_r, verdict_nxt;

  always_comb begin
    maker_nxt   = {MASK_MAKER_ID, fuse_maker_i};
    secret_nxt  = secret_req_i ? secret_fuses_i : 64'h0;
    verdict_nxt = compare_i ? (digest_i == response_i) : verdict_r;
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      maker_r   <= '0;
      secret_r  <= '0;
      verdict_r <= 1'b0;
    end else begin
      maker_r   <= maker_nxt;
      secret_r  <= secret_nxt;
      verdict_r <= verdict_nxt;
    end
  end

  // Open drain: the wire is only ever pulled low, never driven high.
  // single shared wire
  assign sig_o              = 1'b0;
  assign sig_oe_o           = line_low && (state_r != ST_SLEEP);
  assign rx_data_o          = rxd_r;
  assign rx_valid_o         = rxv_r;
  assign cmd_end_o          = cend_r;
  assign tx_ready_o         = (state_r == ST_TX) && !txact_r;
  assign maker_ident_code_o = maker_r;
  assign secret_word_o      = secret_r;
  assign verdict_o          = verdict_r;
  assign asleep_o           = (state_r == ST_SLEEP);

endmodule
`default_nettype wire

// file: bench/swi_link_chk.sv
// Purpose: Concurrent port checks for the single-wire token link.
// Assumes: One clock mclk_i; sys_rst_i asynchronous, active high.
// Notes:   Long spans use helper counters, since repetitions stay short.
`timescale 1ns/10ps
`default_nettype none
module swi_link_chk
  import swi_pkg::*;
#(
  parameter int     IO_IDLE_LIMIT = 2000,
  parameter int     IGNORE_LIMIT  = 1000,
  parameter longint WDOG_LIMIT    = 20000
) (
  // Clock and reset
  input wire logic         mclk_i,
  input wire logic         sys_rst_i,
  // Wire and link side
  input wire logic         sig_i,
  input wire logic         sig_o,
  input wire logic         sig_oe_o,
  input wire logic         rx_valid_o,
  input wire logic         cmd_end_o,
  input wire logic         busy_i,
  input wire logic         bus_ignore_command_i,
  input wire logic         asleep_o,
  // Digest support
  input wire logic [7:0]   fuse_maker_i,
  input wire logic [63:0]  secret_fuses_i,
  input wire logic         secret_req_i,
  input wire logic [255:0] digest_i,
  input wire logic [255:0] response_i,
  input wire logic         compare_i,
  input wire logic [23:0]  maker_ident_code_o,
  input wire logic [63:0]  secret_word_o,
  input wire logic         verdict_o
);
  // ----------------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------------
  logic [31:0] idle_r;
  logic [31:0] wake_r;
  logic [31:0] pz_r;
  logic [31:0] low_r;
  logic [7:0]  oe_r;
  logic        sig_q_r;
  logic        match_r;

  // The idle count is held at zero while the wire is low, the link sleeps or drives, busy_i is high or the ignore window runs.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      idle_r  <= '0;
      wake_r  <= '0;
      pz_r    <= '0;
      low_r   <= '0;
      oe_r    <= '0;
      sig_q_r <= 1'b1;
      match_r <= 1'b0;
    end else begin
      idle_r  <= (!sig_i || asleep_o || sig_oe_o || busy_i || pz_r != 0) ?
                 '0 : idle_r + 1;
      wake_r  <= asleep_o ? '0 : wake_r + 1;
      pz_r    <= bus_ignore_command_i ? 32'(IGNORE_LIMIT) :
                 (pz_r != 0 ? pz_r - 1 : '0);
      low_r   <= sig_i ? low_r : (sig_q_r ? 32'h1 : low_r + 1);
      oe_r    <= sig_oe_o ? oe_r + 1 : '0;
      sig_q_r <= sig_i;
      match_r <= (digest_i == response_i);
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_maker_code: assert property (
    !$past(sys_rst_i) |->
      maker_ident_code_o == {MASK_MAKER_ID, $past(fuse_maker_i)})
    else $error("maker code mismatch");
  a_secret_gate: assert property (
    !$past(sys_rst_i) |-> secret_word_o ==
      ($past(secret_req_i) ? $past(secret_fuses_i) : 64'h0))
    else $error("secret word mismatch");
  a_verdict_match: assert property (
    compare_i |=> verdict_o == match_r)
    else $error("verdict mismatch");
  a_sleep_quiet: assert property (
    asleep_o |-> !sig_oe_o && !sig_o)
    else $error("wire driven while asleep");
  a_pulse_width: assert property (
    $fell(sig_oe_o) |-> oe_r inside {[46:86]})
    else $error("device pulse width out of range");
  a_idle_limit: assert property (
    idle_r <= IO_IDLE_LIMIT + 10)
    else $error("idle limit passed while awake");
  a_wdog_limit: assert property (
    wake_r <= WDOG_LIMIT + 10)
    else $error("watchdog limit passed while awake");
  a_wake_min: assert property (
    asleep_o && low_r < WAKE_LOW_CYC - 40 |=> asleep_o)
    else $error("woke on a short low");
  a_end_with_byte: assert property (
    cmd_end_o |-> rx_valid_o)
    else $error("block end without byte");
  a_pause_quiet: assert property (
    pz_r != 0 |-> !rx_valid_o && !sig_oe_o)
    else $error("activity inside ignore window");
endmodule

bind swi_link swi_link_chk #(
  .IO_IDLE_LIMIT (IO_IDLE_LIMIT),
  .IGNORE_LIMIT  (IGNORE_LIMIT),
  .WDOG_LIMIT    (WDOG_LIMIT)
) u_chk (.*);
`default_nettype wire

// file: bench/swi_sys_model.sv
// Purpose: System master on the single wire, sending and reading tokens.
// Assumes: Wire has a pull-up; tasks are entered just after a clock edge.
// Notes:   Settle time after wake is scaled to the shortened idle limit.
`timescale 1ns/10ps
`default_nettype none
module swi_sys_model #(
  parameter int START_CYC  = 43,
  parameter int BIT_CYC    = 390,
  parameter int SETTLE_CYC = 300
) (
  input  wire logic clk_i,
  input  wire logic line_i,
  output var  logic pull_low_o
);
  initial pull_low_o = 1'b0;

  task automatic hold_low(input int n);
    pull_low_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    pull_low_o <= 1'b0;
  endtask

  task automatic wake(input int n);
    hold_low(n);
    repeat (SETTLE_CYC) @(posedge clk_i);
  endtask

  task automatic glitch(input int ns);
    @(posedge clk_i);
    #20 pull_low_o = 1'b1;
    #(ns) pull_low_o = 1'b0;
    @(posedge clk_i);
  endtask

  task automatic send_bit(input logic b);
    hold_low(START_CYC);
    if (!b) begin
      repeat (START_CYC) @(posedge clk_i);
      hold_low(START_CYC);
    end
    repeat (BIT_CYC - (b ? 1 : 3) * START_CYC) @(posedge clk_i);
  endtask

  task automatic send_byte(input logic [7:0] d);
    for (int i = 0; i < 8; i++) send_bit(d[i]);
  endtask

  // A zero shows a second fall soon after the start fall.
  task automatic recv_byte(output logic [7:0] d, output int gap);
    int   n;
    int   g;
    logic prev;
    for (int i = 0; i < 8; i++) begin
      g = 0;
      n = 0;
      prev = 1'b0;
      while (line_i && g < 5000) begin
        @(negedge clk_i);
        g++;
      end
      repeat (200) begin
        @(negedge clk_i);
        if (prev && !line_i) n++;
        prev = line_i;
      end
      d[i] = (n == 0);
      if (i == 0) gap = g;
    end
  endtask
endmodule
`default_nettype wire

// file: bench/single_wire_token_link_bench.sv
// Purpose: Self-checking bench for the device end of the token link.
// Assumes: Shortened idle, ignore and watchdog counts.
// Notes:   The wire is open drain with a pull-up; both ends pull low.
`timescale 1ns/10ps
`default_nettype none
module single_wire_token_link_bench;
  import swi_pkg::*;
  localparam int     IDLE = 2000;
  localparam int     IGN  = 1000;
  localparam longint WDOG = 20000;

  logic         mclk_i = 1'b0;
  logic         sys_rst_i = 1'b1;
  logic         busy_i, bus_ignore_command_i, tx_valid_i, tx_last_i;
  logic         secret_req_i, compare_i;
  logic [7:0]   tx_data_i, fuse_maker_i;
  logic [63:0]  secret_fuses_i;
  logic [255:0] digest_i, response_i;
  logic         sig_o, sig_oe_o, rx_valid_o, cmd_end_o, tx_ready_o;
  logic         verdict_o, asleep_o, sys_low;
  logic [7:0]   rx_data_o;
  logic [23:0]  maker_ident_code_o;
  logic [63:0]  secret_word_o;
  logic [7:0]   rxq[$];
  int           n_end = 0;
  int           cyc = 0;
  int           num_errors = 0;
  int           n_compared = 0;
  wire logic    line_w;

  assign line_w = !(sys_low || (sig_oe_o && !sig_o));
  always #50 mclk_i = ~mclk_i;

  swi_link #(
    .IO_IDLE_LIMIT (IDLE),
    .IGNORE_LIMIT  (IGN),
    .WDOG_LIMIT    (WDOG)
  ) u_dut (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .sig_i(line_w), .sig_o(sig_o),
    .sig_oe_o(sig_oe_o), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
    .cmd_end_o(cmd_end_o), .busy_i(busy_i),
    .bus_ignore_command_i(bus_ignore_command_i), .tx_data_i(tx_data_i),
    .tx_valid_i(tx_valid_i), .tx_last_i(tx_last_i),
    .tx_ready_o(tx_ready_o), .fuse_maker_i(fuse_maker_i),
    .secret_fuses_i(secret_fuses_i), .secret_req_i(secret_req_i),
    .digest_i(digest_i), .response_i(response_i), .compare_i(compare_i),
    .maker_ident_code_o(maker_ident_code_o),
    .secret_word_o(secret_word_o), .verdict_o(verdict_o),
    .asleep_o(asleep_o)
  );

  swi_sys_model u_sys (
    .clk_i(mclk_i), .line_i(line_w), .pull_low_o(sys_low)
  );

  // ----------------------------------------------------------------------
  // Monitor, timeout and helpers
  // ----------------------------------------------------------------------
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (rx_valid_o) rxq.push_back(rx_data_o);
    if (cmd_end_o) n_end <= n_end + 1;
    if (cyc == 90000) begin
      num_errors++;
      $display("ERROR %0t: run did not finish", $time);
      results();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic feed(input logic [7:0] d, input logic last);
    int k;
    k = 0;
    tx_data_i  <= d;
    tx_last_i  <= last;
    tx_valid_i <= 1'b1;
    do begin
      @(negedge mclk_i);
      k++;
    end while (!tx_ready_o && k < 8000);
    @(posedge mclk_i);
  endtask

  task automatic results();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    {busy_i, bus_ignore_command_i, tx_valid_i, tx_last_i} <= '0;
    {secret_req_i, compare_i, tx_data_i, fuse_maker_i} <= '0;
    {secret_fuses_i, digest_i, response_i} <= '0;
    tick(2);
    check(asleep_o, 1'b1);
    check(sig_oe_o, 1'b0);
    tick(2);
    sys_rst_i <= 1'b0;
    tick(2);
  endtask

  task automatic t_digest();
    for (int i = 0; i < 2; i++) begin
      fuse_maker_i   <= i ? 8'hc3 : 8'h3c;
      secret_req_i   <= i[0];
      secret_fuses_i <= 64'ha5a5_0f0f_c3c3_9696;
      digest_i       <= {8{32'h1234_5678}};
      response_i     <= {8{i ? 32'h1234_5678 : 32'h8765_4321}};
      compare_i      <= 1'b1;
      tick(1);
      compare_i <= 1'b0;
      tick(2);
      check(maker_ident_code_o, {MASK_MAKER_ID, i ? 8'hc3 : 8'h3c});
      check(secret_word_o, i ? 64'ha5a5_0f0f_c3c3_9696 : 64'h0);
      check(verdict_o, i[0]);
    end
  endtask

  task automatic t_wake();
    u_sys.glitch(400);
    tick(20);
    check(asleep_o, 1'b1);
    u_sys.wake(650);
    check(asleep_o, 1'b0);
  endtask

  // Busy is raised early so the trailing byte must be ignored.
  task automatic t_cmd();
    logic [7:0] msg [4] = '{FLAG_CMD, 8'h03, 8'ha5, 8'h3c};
    u_sys.glitch(40);
    busy_i <= 1'b1;
    rxq.delete();
    foreach (msg[i]) u_sys.send_byte(msg[i]);
    check(rxq.size(), 3);
    for (int i = 1; i < 4; i++) check(rxq[i-1], msg[i]);
    check(n_end, 1);
    u_sys.send_byte(8'h0f);
    check(rxq.size(), 3);
    busy_i <= 1'b0;
    tick(5);
    u_sys.send_byte(8'h5a);
    check(rxq.size(), 3);
    check(asleep_o, 1'b0);
    u_sys.send_byte(FLAG_SLEEP);
    check(asleep_o, 1'b1);
  endtask

  task automatic t_tx();
    logic [7:0] d0;
    logic [7:0] d1;
    int         gap;
    int         g;
    u_sys.wake(650);
    fork
      begin
        u_sys.send_byte(FLAG_TX);
        u_sys.recv_byte(d0, gap);
        u_sys.recv_byte(d1, g);
      end
      begin
        feed(8'h96, 1'b0);
        feed(8'h01, 1'b1);
        tx_valid_i <= 1'b0;
      end
    join
    check(d0, 8'h96);
    check(d1, 8'h01);
    check(gap inside {[280:950]}, 1'b1);
    tick(500);
  endtask

  // Two zeros during the window would misalign the sleep flag.
  task automatic t_pause();
    bus_ignore_command_i <= 1'b1;
    tick(1);
    bus_ignore_command_i <= 1'b0;
    u_sys.send_bit(1'b0);
    u_sys.send_bit(1'b0);
    tick(300);
    u_sys.send_byte(FLAG_SLEEP);
    tick(5);
    check(asleep_o, 1'b1);
  endtask

  task automatic t_idle();
    int n;
    n = 0;
    u_sys.wake(650);
    while (!asleep_o && n < 3000) begin
      tick(1);
      n++;
    end
    check(n inside {[IDLE-960:IDLE-280]}, 1'b1);
  endtask

  task automatic t_watch();
    int k;
    k = 0;
    u_sys.wake(650);
    while (!asleep_o && k < 70) begin
      u_sys.send_bit(1'b1);
      k++;
    end
    check(k * 390 inside {[WDOG-400:WDOG+400]}, 1'b1);
  endtask

  initial begin
    t_reset();
    t_digest();
    t_wake();
    t_cmd();
    t_tx();
    t_pause();
    t_idle();
    t_watch();
    results();
  end
endmodule
`default_nettype wire
